// >>> design/mcit_cfg.svh
`ifndef MCIT_CFG_SVH
`define MCIT_CFG_SVH

// Widths and reset values
`define MCIT_PC_W        16
`define MCIT_RESET_PC    16'h0000
`define MCIT_NUM_BKPT    4
`define MCIT_MAX_CLK_KHZ 25000

// Opcode fields
`define MCIT_OPC_ROW     7:4
`define MCIT_OPC_COL     3:0

// Instruction lengths in bytes
`define MCIT_LEN1        2'h1
`define MCIT_LEN2        2'h2
`define MCIT_LEN3        2'h3

// Execution times in clock cycles
`define MCIT_CYC1        4'h1
`define MCIT_CYC2        4'h2
`define MCIT_CYC3        4'h3
`define MCIT_CYC4        4'h4
`define MCIT_CYC5        4'h5
`define MCIT_CYC8        4'h8
`define MCIT_MAX_CYCLES  4'h8

// Cycle counter points
`define MCIT_CNT_ZERO    4'h0
`define MCIT_CNT_ONE     4'h1
`define MCIT_CNT_TWO     4'h2

`endif

// >>> design/mcit_pkg.sv
`default_nettype none
`include "mcit_cfg.svh"

package mcit_pkg;

	typedef enum logic {
		ST_HALT,
		ST_EXEC
	} mcit_state_t;

	typedef struct packed {
		mcit_state_t             fsm;
		logic [`MCIT_PC_W-1:0]   pc;
		logic [`MCIT_PC_W-1:0]   fetch;
		logic [7:0]              opcode;
		logic [7:0]              operand1;
		logic [7:0]              operand2;
		logic [3:0]              cnt;
		logic [1:0]              len;
		logic [3:0]              cyc;
		logic                    cond;
		logic                    taken;
		logic                    skip;
		logic                    stepping;
		logic                    retire;
		logic [3:0]              retire_cycles;
		logic                    illegal;
		logic                    bkpt_hit;
	} mcit_core_t;

endpackage
`default_nettype wire

// >>> design/mcit_opcode_table.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcit_cfg.svh"

module mcit_opcode_table (
	input  wire logic [7:0] opcode_i,
	output logic            legal_o,
	output logic [1:0]      len_o,
	output logic [3:0]      cycles_o,
	output logic            cond_o
);
	logic [3:0] row;
	logic [3:0] col;

	assign row = opcode_i[`MCIT_OPC_ROW];
	assign col = opcode_i[`MCIT_OPC_COL];

	// Byte count and untaken cycle count per opcode, laid out by column of the opcode map
	always_comb
	begin
		legal_o  = 1'b1;
		len_o    = `MCIT_LEN1;
		cycles_o = `MCIT_CYC1;
		cond_o   = 1'b0;
		unique case (col)
			4'h0:
			begin
				unique case (row)
					4'h0: ;
					4'h1, 4'h2, 4'h3:
					begin
						len_o = `MCIT_LEN3; cycles_o = `MCIT_CYC3; cond_o = 1'b1;
					end
					4'h4, 4'h5, 4'h6, 4'h7:
					begin
						len_o = `MCIT_LEN2; cycles_o = `MCIT_CYC2; cond_o = 1'b1;
					end
					4'h8: begin len_o = `MCIT_LEN2; cycles_o = `MCIT_CYC3; end
					4'h9: begin len_o = `MCIT_LEN3; cycles_o = `MCIT_CYC3; end
					4'hE, 4'hF: cycles_o = `MCIT_CYC3;
					default: begin len_o = `MCIT_LEN2; cycles_o = `MCIT_CYC2; end
				endcase
			end
			// Absolute jump and call share one column
			4'h1: begin len_o = `MCIT_LEN2; cycles_o = `MCIT_CYC3; end
			4'h2:
			begin
				unique case (row)
					4'h0, 4'h1: begin len_o = `MCIT_LEN3; cycles_o = `MCIT_CYC4; end
					4'h2, 4'h3: cycles_o = `MCIT_CYC5;
					4'hE, 4'hF: cycles_o = `MCIT_CYC3;
					default: begin len_o = `MCIT_LEN2; cycles_o = `MCIT_CYC2; end
				endcase
			end
			4'h3:
			begin
				unique case (row)
					4'h4, 4'h5, 4'h6: begin len_o = `MCIT_LEN3; cycles_o = `MCIT_CYC3; end
					4'h7, 4'h8, 4'h9, 4'hE, 4'hF: cycles_o = `MCIT_CYC3;
					default: ;
				endcase
			end
			4'h4:
			begin
				unique case (row)
					4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: ;
					4'h8: cycles_o = `MCIT_CYC8;
					4'hA: cycles_o = `MCIT_CYC4;
					4'hB: begin len_o = `MCIT_LEN3; cycles_o = `MCIT_CYC3; cond_o = 1'b1; end
					default: begin len_o = `MCIT_LEN2; cycles_o = `MCIT_CYC2; end
				endcase
			end
			4'h5:
			begin
				unique case (row)
					4'h7, 4'h8: begin len_o = `MCIT_LEN3; cycles_o = `MCIT_CYC3; end
					4'hA: legal_o = 1'b0;
					4'hB, 4'hD: begin len_o = `MCIT_LEN3; cycles_o = `MCIT_CYC3; cond_o = 1'b1; end
					default: begin len_o = `MCIT_LEN2; cycles_o = `MCIT_CYC2; end
				endcase
			end
			4'h6, 4'h7:
			begin
				unique case (row)
					4'h7, 4'h8, 4'hA: begin len_o = `MCIT_LEN2; cycles_o = `MCIT_CYC2; end
					4'hB: begin len_o = `MCIT_LEN3; cycles_o = `MCIT_CYC4; cond_o = 1'b1; end
					default: cycles_o = `MCIT_CYC2;
				endcase
			end
			default:
			begin
				unique case (row)
					4'h7, 4'h8, 4'hA: begin len_o = `MCIT_LEN2; cycles_o = `MCIT_CYC2; end
					4'hB: begin len_o = `MCIT_LEN3; cycles_o = `MCIT_CYC3; cond_o = 1'b1; end
					4'hD: begin len_o = `MCIT_LEN2; cycles_o = `MCIT_CYC2; cond_o = 1'b1; end
					default: ;
				endcase
			end
		endcase
	end

endmodule
`default_nettype wire

// >>> design/mcit_core_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcit_cfg.svh"

module mcit_core_timing (
	input  wire logic                                      clock_i,
	input  wire logic                                      rst_n_i,
	// Code memory, combinational read of code_addr_o
	output logic [`MCIT_PC_W-1:0]                          code_addr_o,
	input  wire logic [7:0]                                code_data_i,
	// Datapath hand-shake
	input  wire logic                                      branch_cond_i,
	input  wire logic                                      pc_load_i,
	input  wire logic [`MCIT_PC_W-1:0]                     pc_target_i,
	output logic [`MCIT_PC_W-1:0]                          pc_o,
	output logic [7:0]                                     opcode_o,
	output logic [7:0]                                     operand1_o,
	output logic [7:0]                                     operand2_o,
	output logic [3:0]                                     cycle_o,
	output logic                                           retire_o,
	output logic [3:0]                                     retire_cycles_o,
	output logic                                           illegal_o,
	// Debug control
	input  wire logic                                      halt_req_i,
	input  wire logic                                      run_req_i,
	input  wire logic                                      step_req_i,
	input  wire logic [`MCIT_NUM_BKPT-1:0]                 bkpt_en_i,
	input  wire logic [`MCIT_NUM_BKPT-1:0][`MCIT_PC_W-1:0] bkpt_addr_i,
	output logic                                           bkpt_hit_o,
	output logic                                           halted_o,
	output logic                                           dbg_grant_o
);
	import mcit_pkg::*;

	// Whole core state and its next value
	mcit_core_t s;
	mcit_core_t next_s;

	// Decode table outputs for the byte now on the code bus
	logic                  tbl_legal;
	logic [1:0]            tbl_len;
	logic [3:0]            tbl_cyc;
	logic                  tbl_cond;
	// Current instruction as seen in this cycle
	logic                  first;
	logic [1:0]            cur_len;
	logic [3:0]            cur_cyc;
	logic                  cur_cond;
	// Sequencing decisions
	logic                  resolve;
	logic                  fin_plain;
	logic                  fin_taken;
	logic                  fin_cap;
	logic                  finish;
	logic                  jump;
	logic [`MCIT_PC_W-1:0] next_pc;
	logic                  fetch_more;
	logic                  take_op1;
	logic                  take_op2;
	// Debug decisions
	logic                  resume;
	logic                  bkpt_stop;

	// Address step shared by fetch pointer and fall-through pc
	function automatic logic [`MCIT_PC_W-1:0] pc_add(input logic [`MCIT_PC_W-1:0] base,
	                                                input logic [1:0] n);
		pc_add = base + {{(`MCIT_PC_W-2){1'b0}}, n};
	endfunction

	// True when any enabled breakpoint matches the address
	function automatic logic bkpt_match(input logic [`MCIT_PC_W-1:0] addr,
	                                    input logic [`MCIT_NUM_BKPT-1:0] en,
	                                    input logic [`MCIT_NUM_BKPT-1:0][`MCIT_PC_W-1:0] tab);
		bkpt_match = 1'b0;
		for (int i = 0; i < `MCIT_NUM_BKPT; i++)
		begin
			if (en[i] && (tab[i] == addr))
				bkpt_match = 1'b1;
		end
	endfunction

	// Decode is only meaningful in the first cycle, when the opcode byte is on the bus
	mcit_opcode_table mcit_opcode_table_inst (
		.opcode_i (code_data_i),
		.legal_o  (tbl_legal),
		.len_o    (tbl_len),
		.cycles_o (tbl_cyc),
		.cond_o   (tbl_cond)
	);

	// Current instruction view: table in cycle 0, latched copy afterwards
	assign first    = (s.cnt == `MCIT_CNT_ZERO);
	assign cur_len  = first ? tbl_len : s.len;
	assign cur_cyc  = first ? tbl_cyc : s.cyc;
	assign cur_cond = first ? tbl_cond : s.cond;

	// Branch resolves on the last untaken cycle; a taken branch runs one cycle more
	assign resolve   = (s.cnt == (cur_cyc - `MCIT_CNT_ONE));
	assign fin_plain = resolve && !(cur_cond && branch_cond_i);
	assign fin_taken = s.taken && (s.cnt == s.cyc);
	// Cap is a safety net: only the 8-cycle entry reaches it, together with its normal finish, but a bad latch cannot hang the core
	assign fin_cap   = (s.cnt == (`MCIT_MAX_CYCLES - `MCIT_CNT_ONE));
	assign finish    = fin_plain || fin_taken || fin_cap;

	// Taken flag belongs to the branch that set it; it is cleared at every finish
	assign jump      = pc_load_i || s.taken;
	assign next_pc   = jump ? pc_target_i : pc_add(s.pc, cur_len);

	// Fetch steps only while bytes of this instruction remain
	assign fetch_more = ((s.cnt + `MCIT_CNT_ONE) < {2'h0, cur_len});
	// Second and third bytes are on the bus in cycles one and two
	assign take_op1   = (s.cnt == `MCIT_CNT_ONE) && (s.len != `MCIT_LEN1);
	assign take_op2   = (s.cnt == `MCIT_CNT_TWO) && (s.len == `MCIT_LEN3);

	// Debug requests and breakpoint compare
	assign resume     = run_req_i || step_req_i;
	assign bkpt_stop  = first && !s.skip && bkpt_match(s.pc, bkpt_en_i, bkpt_addr_i);

	// Sequencer: at most one program byte fetched per clock, counted in whole clock cycles
	always_comb
	begin
		next_s          = s;
		next_s.retire   = 1'b0;
		next_s.illegal  = 1'b0;
		next_s.bkpt_hit = 1'b0;
		unique case (s.fsm)
			// Core makes no fetches while halted, so the debugger owns memory
			ST_HALT:
			begin
				if (resume)
				begin
					next_s.fsm      = ST_EXEC;
					next_s.skip     = 1'b1;
					next_s.stepping = step_req_i;
				end
			end
			ST_EXEC:
			begin
				// Breakpoint halts before the instruction starts; skipped once on resume
				if (bkpt_stop)
				begin
					next_s.fsm      = ST_HALT;
					next_s.bkpt_hit = 1'b1;
				end
				else
				begin
					next_s.cnt = s.cnt + `MCIT_CNT_ONE;
					// Latch decode so later cycles do not depend on the bus
					if (first)
					begin
						next_s.opcode  = code_data_i;
						next_s.len     = tbl_len;
						next_s.cyc     = tbl_cyc;
						next_s.cond    = tbl_cond;
						next_s.taken   = 1'b0;
						next_s.skip    = 1'b0;
						next_s.illegal = !tbl_legal;
					end
					// Operand bytes are latched as they pass on the code bus
					if (take_op1)
						next_s.operand1 = code_data_i;
					if (take_op2)
						next_s.operand2 = code_data_i;
					// No fetch runs ahead of the instruction, so nothing is thrown away on a jump
					if (fetch_more)
						next_s.fetch = pc_add(s.fetch, `MCIT_LEN1);
					if (resolve)
						next_s.taken = cur_cond && branch_cond_i;
					// Last cycle: move on to the next instruction or the jump target
					if (finish)
					begin
						next_s.cnt           = `MCIT_CNT_ZERO;
						next_s.pc            = next_pc;
						next_s.fetch         = next_pc;
						next_s.taken         = 1'b0;
						next_s.retire        = 1'b1;
						next_s.retire_cycles = s.cnt + `MCIT_CNT_ONE;
						// Halt or single step takes effect only between instructions
						if (halt_req_i || s.stepping)
						begin
							next_s.fsm      = ST_HALT;
							next_s.stepping = 1'b0;
						end
					end
				end
			end
		endcase
	end

	// Whole core state in one register; debug fields are private to this block
	// Fully static, so the clock may stop or run at any rate up to the top one
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		// Reset leaves the core running from the reset address
		if (!rst_n_i)
		begin
			s               <= '0;
			s.fsm           <= ST_EXEC;
			s.pc            <= `MCIT_RESET_PC;
			s.fetch         <= `MCIT_RESET_PC;
		end
		else
			s <= next_s;
	end

	// Outputs straight from the state register
	assign code_addr_o     = s.fetch;
	assign pc_o            = s.pc;
	assign opcode_o        = s.opcode;
	assign operand1_o      = s.operand1;
	assign operand2_o      = s.operand2;
	assign cycle_o         = s.cnt;
	assign retire_o        = s.retire;
	assign retire_cycles_o = s.retire_cycles;
	assign illegal_o       = s.illegal;

	// Debug status; the debugger owns memory only while the core is halted
	assign bkpt_hit_o      = s.bkpt_hit;
	assign halted_o        = (s.fsm == ST_HALT);
	assign dbg_grant_o     = (s.fsm == ST_HALT);

endmodule
`default_nettype wire

// >>> verification/mcit_core_timing_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcit_cfg.svh"

module mcit_core_timing_monitor (
	input  wire logic                  clock_i,
	input  wire logic                  rst_n_i,
	input  wire logic [`MCIT_PC_W-1:0] code_addr_o,
	input  wire logic [`MCIT_PC_W-1:0] pc_o,
	input  wire logic [7:0]            opcode_o,
	input  wire logic [3:0]            cycle_o,
	input  wire logic                  retire_o,
	input  wire logic [3:0]            retire_cycles_o,
	input  wire logic                  illegal_o,
	input  wire logic                  branch_cond_i,
	input  wire logic                  run_req_i,
	input  wire logic                  step_req_i,
	input  wire logic                  bkpt_hit_o,
	input  wire logic                  halted_o,
	input  wire logic                  dbg_grant_o
);
	// Single clock domain, so clock and reset are stated once
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	// A step leaves halt, runs one instruction, then halts again
	sequence seq_step_leave;
		halted_o && step_req_i ##1 !halted_o;
	endsequence
	sequence seq_halt_back;
		##[1:9] halted_o;
	endsequence

	chk_cycle_cap: assert property (retire_o |-> retire_cycles_o inside {[4'h1:4'h8]})
		else $error("retired cycle count out of range");
	chk_divide_eight: assert property (retire_o && opcode_o == 8'h84 |-> retire_cycles_o == 4'h8)
		else $error("divide did not take eight cycles");
	chk_branch_saving: assert property (retire_o && opcode_o == 8'h40 |->
		(retire_cycles_o == 4'h2 && !$past(branch_cond_i)) || (retire_cycles_o == 4'h3 && $past(branch_cond_i, 2)))
		else $error("branch cycle count does not match its condition");
	chk_retire_boundary: assert property (retire_o |-> cycle_o == 4'h0)
		else $error("retire away from an instruction boundary");
	chk_illegal_flag: assert property (illegal_o |-> opcode_o == 8'hA5 && retire_o)
		else $error("illegal flag on a defined opcode");
	chk_grant_level: assert property (dbg_grant_o == halted_o && (!dbg_grant_o || cycle_o == 4'h0))
		else $error("debug grant differs from halt state");
	chk_halt_hold: assert property (halted_o && !run_req_i && !step_req_i |=> halted_o)
		else $error("core left halt without a request");
	chk_halt_frozen: assert property (halted_o && $past(halted_o) |-> $stable(code_addr_o))
		else $error("fetch advanced while halted");
	chk_resume_prompt: assert property (halted_o && (run_req_i || step_req_i) |=> !halted_o)
		else $error("run or step did not resume the core");
	chk_step_single: assert property (seq_step_leave |-> seq_halt_back)
		else $error("step did not halt after one instruction");
	chk_bkpt_stop: assert property (bkpt_hit_o |-> halted_o && !retire_o && $stable(pc_o))
		else $error("breakpoint hit without a clean halt");
endmodule

bind mcit_core_timing mcit_core_timing_monitor mcit_core_timing_monitor_inst (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .code_addr_o(code_addr_o), .pc_o(pc_o), .opcode_o(opcode_o),
	.cycle_o(cycle_o), .retire_o(retire_o), .retire_cycles_o(retire_cycles_o), .illegal_o(illegal_o),
	.branch_cond_i(branch_cond_i), .run_req_i(run_req_i), .step_req_i(step_req_i),
	.bkpt_hit_o(bkpt_hit_o), .halted_o(halted_o), .dbg_grant_o(dbg_grant_o)
);
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcit_cfg.svh"

module tb_top;
	logic                  clock_i;
	logic                  rst_n_i = 1'b0;
	logic                  branch_cond_i = 1'b0;
	logic                  pc_load_i = 1'b0;
	logic                  halt_req_i = 1'b0;
	logic                  run_req_i = 1'b0;
	logic                  step_req_i = 1'b0;
	logic [3:0]            bkpt_en_i = 4'h0;
	logic [3:0][15:0]      bkpt_addr_i = '0;
	logic [15:0]           pc_target_i = 16'h0000;
	logic [15:0]           code_addr_o, pc_o;
	logic [7:0]            code_data_i, opcode_o, operand1_o, operand2_o;
	logic [3:0]            cycle_o, retire_cycles_o;
	logic                  retire_o, illegal_o, bkpt_hit_o, halted_o, dbg_grant_o;
	logic [7:0]            mem [0:255];
	int                    n_fail = 0;
	int                    n_compared = 0;
	// Program: arithmetic, logic, divide, multiply, branches, long jump, undefined opcode
	localparam logic [7:0] PROG [28] = '{8'h28, 8'h26, 8'h24, 8'h11, 8'h34, 8'h22, 8'h94, 8'h33, 8'h53, 8'h40,
		8'h0F, 8'h43, 8'h41, 8'hF0, 8'h63, 8'h42, 8'hAA, 8'h52, 8'h43, 8'h55, 8'h44, 8'h56, 8'h84, 8'hA4,
		8'h40, 8'h05, 8'h40, 8'h14};
	localparam logic [7:0] PROG2 [7] = '{8'h20, 8'h08, 8'h10, 8'h00, 8'h02, 8'h00, 8'h40};
	localparam logic [15:0] EXP_PC [19] = '{16'h0001, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000B,
		16'h000E, 16'h0011, 16'h0013, 16'h0015, 16'h0016, 16'h0017, 16'h0018, 16'h001A, 16'h0030, 16'h0033,
		16'h0034, 16'h0040, 16'h0041};
	localparam logic [3:0] EXP_CYC [19] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h2, 4'h2,
		4'h2, 4'h8, 4'h4, 4'h2, 4'h3, 4'h3, 4'h1, 4'h4, 4'h1};

	mcit_core_timing mcit_core_timing_inst (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .code_addr_o(code_addr_o), .code_data_i(code_data_i),
		.branch_cond_i(branch_cond_i), .pc_load_i(pc_load_i), .pc_target_i(pc_target_i), .pc_o(pc_o),
		.opcode_o(opcode_o), .operand1_o(operand1_o), .operand2_o(operand2_o),
		.cycle_o(cycle_o), .retire_o(retire_o),
		.retire_cycles_o(retire_cycles_o), .illegal_o(illegal_o), .halt_req_i(halt_req_i),
		.run_req_i(run_req_i), .step_req_i(step_req_i), .bkpt_en_i(bkpt_en_i), .bkpt_addr_i(bkpt_addr_i),
		.bkpt_hit_o(bkpt_hit_o), .halted_o(halted_o), .dbg_grant_o(dbg_grant_o)
	);

	// Code memory answers in the same cycle, as the fetch expects
	assign code_data_i = mem[code_addr_o[7:0]];

	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	// Datapath stand-in: the jump at 0x1A is taken, the long jump at 0x34 loads 0x40
	// Load drops after the long jump's last cycle so the next instruction falls through
	always @(posedge clock_i)
	begin
		branch_cond_i <= (pc_o == 16'h001A);
		pc_load_i <= (pc_o == 16'h0034) && (cycle_o != 4'h3);
		pc_target_i <= (pc_o == 16'h0034) ? 16'h0040 : 16'h0030;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Bounded waits sample one step after the edge, once its updates have landed
	task automatic wait_retire();
		int k = 0;
		do
		begin
			@(posedge clock_i);
			#1 k++;
		end while (retire_o !== 1'b1 && k < 20);
		check(16'(retire_o), 16'h0001);
	endtask

	task automatic wait_halted();
		int k = 0;
		do
		begin
			@(posedge clock_i);
			#1 k++;
		end while (halted_o !== 1'b1 && k < 100);
		check(16'(halted_o), 16'h0001);
	endtask

	task automatic test_timing();
		for (int i = 0; i < 19; i++)
		begin
			wait_retire();
			check(pc_o, EXP_PC[i]);
			check(16'(retire_cycles_o), 16'(EXP_CYC[i]));
			check(16'(illegal_o), 16'(i == 18));
			if (i == 7)
			begin
				check(16'(operand1_o), 16'h0042);
				check(16'(operand2_o), 16'h00AA);
			end
			if (i == 11)
				check(16'(opcode_o), 16'h0084);
			if (i == 14)
				check(16'(operand1_o), 16'h0014);
		end
		$display("test_timing done");
	endtask

	task automatic test_step();
		logic [15:0] p;
		logic [15:0] a;
		@(posedge clock_i);
		halt_req_i <= 1'b1;
		wait_halted();
		p = pc_o;
		a = code_addr_o;
		check(16'(dbg_grant_o), 16'h0001);
		@(posedge clock_i);
		halt_req_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		step_req_i <= 1'b1;
		#1 check(code_addr_o, a);
		@(posedge clock_i);
		step_req_i <= 1'b0;
		#1 check(16'(halted_o), 16'h0000);
		wait_retire();
		check(16'(halted_o), 16'h0001);
		check(pc_o, p + 16'h0001);
		@(posedge clock_i);
		run_req_i <= 1'b1;
		@(posedge clock_i);
		run_req_i <= 1'b0;
		#1 check(16'(halted_o), 16'h0000);
		check(16'(dbg_grant_o), 16'h0000);
		$display("test_step done");
	endtask

	// Entry 0 is disabled and must be passed; entry 2 must stop the core
	task automatic test_bkpt();
		@(posedge clock_i);
		bkpt_addr_i[0] <= 16'h0050;
		bkpt_addr_i[2] <= 16'h0060;
		bkpt_en_i <= 4'b0100;
		wait_halted();
		check(16'(bkpt_hit_o), 16'h0001);
		check(pc_o, 16'h0060);
		@(posedge clock_i);
		run_req_i <= 1'b1;
		@(posedge clock_i);
		run_req_i <= 1'b0;
		wait_retire();
		check(pc_o, 16'h0061);
		check(16'(halted_o), 16'h0000);
		$display("test_bkpt done");
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'h00;
		for (int i = 0; i < 28; i++)
			mem[i] = PROG[i];
		for (int i = 0; i < 7; i++)
			mem[8'h30 + i] = PROG2[i];
		mem[8'h40] = 8'hA5;
		repeat (20) @(posedge clock_i);
		#1 check(pc_o, 16'h0000);
		check(16'(halted_o), 16'h0000);
		@(posedge clock_i);
		rst_n_i <= 1'b1;
		test_timing();
		test_step();
		test_bkpt();
		summarize();
	end

	// Whole run needs well under two hundred cycles; this cuts a hang short
	initial
	begin
		repeat (4000) @(posedge clock_i);
		n_fail++;
		summarize();
	end
endmodule
`default_nettype wire
